// *** design/i2cs_pkg.sv ***
// Constants and types shared by the two-wire slave port.
`default_nettype none
package i2cs_pkg;
  localparam logic [3:0] I2CS_MODE_SLAVE7  = 4'h6;
  localparam logic [3:0] I2CS_MODE_SLAVE10 = 4'h7;
  localparam logic [3:0] I2CS_MODE_MASTER  = 4'hB;
  localparam logic [7:0] I2CS_GCALL_ADDR   = 8'h00;
  localparam logic [7:0] I2CS_BUF_RST      = 8'h00;
  localparam logic [7:0] I2CS_ADDR_RST     = 8'h00;
  localparam logic [3:0] I2CS_BYTE_BITS    = 4'h8;
  localparam logic [3:0] I2CS_LAST_BIT     = 4'h7;
  localparam logic [3:0] I2CS_CNT_RST      = 4'h0;
  localparam int         I2CS_SYNC_STAGES  = 3;

  typedef enum logic [2:0] {
    I2CS_ST_IDLE,
    I2CS_ST_RX,
    I2CS_ST_ACK,
    I2CS_ST_TX,
    I2CS_ST_TXACK
  } i2cs_state_type;

  typedef enum logic [1:0] {
    I2CS_PH_ADDR1,
    I2CS_PH_ADDR2,
    I2CS_PH_DATA
  } i2cs_phase_type;
endpackage
`default_nettype wire

// *** design/i2cs_slave_port.sv ***
// Two-wire slave port: link-clock shifter and system-clock control.
`timescale 1ns/10ps
`default_nettype none
module i2cs_slave_port
  import i2cs_pkg::*;
(
  input  wire logic       sys_clk_in,
  input  wire logic       rstn_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            scl_out,
  output logic            scl_oe_n_out,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  input  wire logic       port_enable_in,
  input  wire logic [3:0] mode_in,
  input  wire logic       general_call_enable_in,
  input  wire logic       addr_wr_in,
  input  wire logic [7:0] addr_data_in,
  input  wire logic       buf_rd_in,
  input  wire logic       buf_wr_in,
  input  wire logic [7:0] buf_data_in,
  input  wire logic       clock_release_set_in,
  input  wire logic       irq_clr_in,
  input  wire logic       ovf_clr_in,
  output logic [7:0]      rx_tx_buffer_out,
  output logic [7:0]      slave_address_out,
  output logic            buffer_full_out,
  output logic            rx_overflow_out,
  output logic            update_address_out,
  output logic            read_write_out,
  output logic            clock_release_out,
  output logic            port_irq_flag_out
);

  function automatic logic addr7_match(input logic [7:0] rx, input logic [7:0] adr);
    addr7_match = (rx[7:1] == adr[7:1]);
  endfunction

  // Link-clock domain: frame counter, shifter and event toggles.
  logic       frame_rst_ff;
  logic       link_rstn;
  logic [3:0] bit_cnt_ff;
  logic [7:0] shift_register;
  logic       byte_tgl_ff;
  logic       ack_tgl_ff;
  logic       ack_lvl_ff;

  // The counter restarts on each start by an async clear that is released while the clock is low.
  assign link_rstn = rstn_in & ~frame_rst_ff;

  always_ff @(posedge scl_in or negedge link_rstn) begin
    if (!link_rstn) begin
      bit_cnt_ff     <= I2CS_CNT_RST;
      shift_register <= I2CS_BUF_RST;
    end else if (bit_cnt_ff == I2CS_BYTE_BITS) begin
      bit_cnt_ff <= I2CS_CNT_RST;
    end else begin
      shift_register <= {shift_register[6:0], sda_in};
      bit_cnt_ff     <= bit_cnt_ff + 4'h1;
    end
  end

  always_ff @(posedge scl_in or negedge rstn_in) begin
    if (!rstn_in) begin
      byte_tgl_ff <= 1'b0;
      ack_tgl_ff  <= 1'b0;
      ack_lvl_ff  <= 1'b1;
    end else if (frame_rst_ff) begin
      byte_tgl_ff <= byte_tgl_ff;
    end else if (bit_cnt_ff == I2CS_BYTE_BITS) begin
      ack_lvl_ff <= sda_in;
      ack_tgl_ff <= ~ack_tgl_ff;
    end else if (bit_cnt_ff == I2CS_LAST_BIT) begin
      byte_tgl_ff <= ~byte_tgl_ff;
    end
  end

  // System-clock domain: synchronisers and edge detection.
  logic [2:0] scl_sync_ff;
  logic [2:0] sda_sync_ff;
  logic [2:0] byte_sync_ff;
  logic [2:0] ack_sync_ff;
  logic       scl_fall;
  logic       start_det;
  logic       stop_det;
  logic       byte_evt;
  logic       ack_evt;

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_sync_ff  <= 3'h7;
      sda_sync_ff  <= 3'h7;
      byte_sync_ff <= 3'h0;
      ack_sync_ff  <= 3'h0;
    end else begin
      scl_sync_ff  <= {scl_sync_ff[1:0], scl_in};
      sda_sync_ff  <= {sda_sync_ff[1:0], sda_in};
      byte_sync_ff <= {byte_sync_ff[1:0], byte_tgl_ff};
      ack_sync_ff  <= {ack_sync_ff[1:0], ack_tgl_ff};
    end
  end

  assign scl_fall  = scl_sync_ff[2] & ~scl_sync_ff[1];
  assign start_det = scl_sync_ff[2] & scl_sync_ff[1] & sda_sync_ff[2] & ~sda_sync_ff[1];
  assign stop_det  = scl_sync_ff[2] & scl_sync_ff[1] & ~sda_sync_ff[2] & sda_sync_ff[1];
  assign byte_evt  = byte_sync_ff[2] ^ byte_sync_ff[1];
  assign ack_evt   = ack_sync_ff[2] ^ ack_sync_ff[1];

  logic active;
  logic mode10;
  assign mode10 = (mode_in == I2CS_MODE_SLAVE10);
  assign active = port_enable_in & ((mode_in == I2CS_MODE_SLAVE7) | mode10);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      frame_rst_ff <= 1'b1;
    end else if (!active || start_det) begin
      frame_rst_ff <= 1'b1;
    end else if (!scl_sync_ff[1]) begin
      frame_rst_ff <= 1'b0;
    end
  end

  // Control state.
  i2cs_state_type state_ff;
  i2cs_phase_type phase_ff;
  logic       pend_ff;
  logic       ack_ff;
  logic       ten_done_ff;
  logic       after_tx_ff;
  logic       after_ua_ff;
  logic       after_idle_ff;
  logic       ack_seen_ff;
  logic [7:0] tx_sr_ff;
  logic [3:0] tx_cnt_ff;
  logic [7:0] buf_ff;
  logic [7:0] addr_ff;
  logic       bf_ff;
  logic       ovf_ff;
  logic       ua_ff;
  logic       rw_ff;
  logic       crel_ff;
  logic       irq_ff;

  logic       decide;
  logic       hit_addr;
  logic       hit_gc;
  logic       hit;
  logic       load_buf;
  logic       set_ovf;
  logic       ack_ok;
  logic       ninth_fall;
  logic       tx_ninth;
  logic       set_ua;

  assign decide     = (state_ff == I2CS_ST_RX) & pend_ff & scl_fall;
  assign ninth_fall = (state_ff == I2CS_ST_ACK) & scl_fall;
  assign tx_ninth   = (state_ff == I2CS_ST_TXACK) & scl_fall;
  assign set_ua     = ninth_fall & after_ua_ff & active;

  always_comb begin
    hit_gc   = general_call_enable_in & (shift_register == I2CS_GCALL_ADDR) & (phase_ff == I2CS_PH_ADDR1);
    hit_addr = 1'b0;
    unique case (phase_ff)
      I2CS_PH_ADDR1: hit_addr = addr7_match(shift_register, addr_ff);
      I2CS_PH_ADDR2: hit_addr = (shift_register == addr_ff);
      I2CS_PH_DATA:  hit_addr = 1'b1;
    endcase
    hit      = hit_addr | hit_gc;
    load_buf = decide & hit & ~bf_ff;
    set_ovf  = decide & hit & bf_ff;
    ack_ok   = ~bf_ff & ~ovf_ff;
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_ff      <= I2CS_ST_IDLE;
      phase_ff      <= I2CS_PH_ADDR1;
      pend_ff       <= 1'b0;
      ack_ff        <= 1'b0;
      ten_done_ff   <= 1'b0;
      after_tx_ff   <= 1'b0;
      after_ua_ff   <= 1'b0;
      after_idle_ff <= 1'b0;
      ack_seen_ff   <= 1'b1;
      tx_cnt_ff     <= I2CS_CNT_RST;
    end else if (!active || stop_det) begin
      state_ff    <= I2CS_ST_IDLE;
      phase_ff    <= I2CS_PH_ADDR1;
      pend_ff     <= 1'b0;
      ten_done_ff <= 1'b0;
    end else if (start_det) begin
      state_ff <= I2CS_ST_RX;
      phase_ff <= I2CS_PH_ADDR1;
      pend_ff  <= 1'b0;
    end else begin
      if (byte_evt && state_ff == I2CS_ST_RX) begin
        pend_ff <= 1'b1;
      end
      if (ack_evt) begin
        ack_seen_ff <= ack_lvl_ff;
      end
      unique case (state_ff)
        I2CS_ST_IDLE: begin
          pend_ff <= 1'b0;
        end
        I2CS_ST_RX: begin
          if (decide) begin
            pend_ff       <= 1'b0;
            state_ff      <= hit ? I2CS_ST_ACK : I2CS_ST_IDLE;
            ack_ff        <= hit & ack_ok;
            // Only a refused address byte ends the transfer; a refused data byte still lets the next one in.
            after_idle_ff <= ~ack_ok & (phase_ff != I2CS_PH_DATA);
            after_tx_ff   <= (phase_ff == I2CS_PH_ADDR1) & hit_addr & shift_register[0] &
                             (~mode10 | ten_done_ff);
            after_ua_ff   <= mode10 & ~hit_gc & ((phase_ff == I2CS_PH_ADDR2) |
                             ((phase_ff == I2CS_PH_ADDR1) & ~ten_done_ff));
            if (phase_ff == I2CS_PH_ADDR2) begin
              ten_done_ff <= 1'b1;
            end
            if (phase_ff == I2CS_PH_ADDR1 && mode10 && !hit_gc && !ten_done_ff) begin
              phase_ff <= I2CS_PH_ADDR2;
            end else begin
              phase_ff <= I2CS_PH_DATA;
            end
          end
        end
        I2CS_ST_ACK: begin
          if (scl_fall) begin
            tx_cnt_ff <= I2CS_CNT_RST;
            if (after_idle_ff) begin
              state_ff <= I2CS_ST_IDLE;
            end else if (after_tx_ff) begin
              state_ff <= I2CS_ST_TX;
            end else begin
              state_ff <= I2CS_ST_RX;
            end
          end
        end
        I2CS_ST_TX: begin
          if (scl_fall) begin
            tx_cnt_ff <= tx_cnt_ff + 4'h1;
            if (tx_cnt_ff == I2CS_LAST_BIT) begin
              state_ff <= I2CS_ST_TXACK;
            end
          end
        end
        I2CS_ST_TXACK: begin
          if (scl_fall) begin
            tx_cnt_ff   <= I2CS_CNT_RST;
            after_tx_ff <= 1'b1;
            state_ff    <= ack_seen_ff ? I2CS_ST_IDLE : I2CS_ST_TX;
            if (ack_seen_ff) begin
              phase_ff <= I2CS_PH_ADDR1;
            end
          end
        end
      endcase
    end
  end

  // Software-visible registers; a hardware set wins over a clear in the same cycle.
  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      buf_ff   <= I2CS_BUF_RST;
      tx_sr_ff <= I2CS_BUF_RST;
      bf_ff    <= 1'b0;
    end else begin
      if (load_buf) begin
        buf_ff <= shift_register;
      end else if (buf_wr_in) begin
        buf_ff <= buf_data_in;
      end
      if (buf_wr_in) begin
        tx_sr_ff <= buf_data_in;
      end else if (state_ff == I2CS_ST_TX && scl_fall) begin
        tx_sr_ff <= {tx_sr_ff[6:0], 1'b1};
      end
      if (load_buf) begin
        bf_ff <= 1'b1;
      end else if (buf_rd_in) begin
        bf_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ovf_ff <= 1'b0;
    end else if (set_ovf) begin
      ovf_ff <= 1'b1;
    end else if (ovf_clr_in) begin
      ovf_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      irq_ff <= 1'b0;
    end else if (ninth_fall || tx_ninth) begin
      irq_ff <= 1'b1;
    end else if (irq_clr_in) begin
      irq_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      addr_ff <= I2CS_ADDR_RST;
      ua_ff   <= 1'b0;
    end else begin
      if (addr_wr_in) begin
        addr_ff <= addr_data_in;
      end
      if (set_ua) begin
        ua_ff <= 1'b1;
      end else if (addr_wr_in || !active) begin
        ua_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rw_ff   <= 1'b0;
      crel_ff <= 1'b1;
    end else begin
      if (decide && hit && phase_ff == I2CS_PH_ADDR1) begin
        rw_ff <= shift_register[0] & ~hit_gc;
      end
      if ((ninth_fall && after_tx_ff && !after_idle_ff) || (tx_ninth && !ack_seen_ff)) begin
        crel_ff <= 1'b0;
      end else if (clock_release_set_in || !active) begin
        crel_ff <= 1'b1;
      end
    end
  end

  // Pins are only ever pulled low; the enable is low while driving.
  logic hold_tx;
  logic drv_sda;
  assign hold_tx = (state_ff == I2CS_ST_TX) & (tx_cnt_ff == I2CS_CNT_RST) & ~crel_ff;
  assign drv_sda = ((state_ff == I2CS_ST_ACK) & ack_ff) |
                   ((state_ff == I2CS_ST_TX) & ~tx_sr_ff[7]);

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      scl_out      <= 1'b0;
      sda_out      <= 1'b0;
      scl_oe_n_out <= 1'b1;
      sda_oe_n_out <= 1'b1;
    end else begin
      scl_out      <= 1'b0;
      sda_out      <= 1'b0;
      scl_oe_n_out <= ~(active & (ua_ff | hold_tx));
      sda_oe_n_out <= ~(active & drv_sda);
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_tx_buffer_out   <= I2CS_BUF_RST;
      slave_address_out  <= I2CS_ADDR_RST;
      buffer_full_out    <= 1'b0;
      rx_overflow_out    <= 1'b0;
      update_address_out <= 1'b0;
      read_write_out     <= 1'b0;
      clock_release_out  <= 1'b1;
      port_irq_flag_out  <= 1'b0;
    end else begin
      rx_tx_buffer_out   <= buf_ff;
      slave_address_out  <= addr_ff;
      buffer_full_out    <= bf_ff;
      rx_overflow_out    <= ovf_ff;
      update_address_out <= ua_ff;
      read_write_out     <= rw_ff;
      clock_release_out  <= crel_ff;
      port_irq_flag_out  <= irq_ff;
    end
  end

  AST_DISABLED_IDLE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    !port_enable_in |=> (state_ff == I2CS_ST_IDLE) && !ua_ff)
    else $error("port not idle while disabled");
  AST_LOAD_ON_FREE: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (decide && hit && !bf_ff) |=> bf_ff && (buf_ff == $past(shift_register)) ##1 buffer_full_out)
    else $error("free buffer not loaded");
  AST_OVF_DISCARD: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (decide && hit && bf_ff) |=> ovf_ff && $stable(buf_ff) && !ack_ff)
    else $error("overflow byte not discarded");
  AST_NO_ACK_ON_OVF: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (decide && hit && ovf_ff && !bf_ff) |=> bf_ff && !ack_ff)
    else $error("acknowledged with overflow set");
  AST_ACK_DRIVES_SDA: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (state_ff == I2CS_ST_ACK && ack_ff && active) |=> !sda_oe_n_out)
    else $error("acknowledge not driven");
  AST_FLAG_NINTH: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ninth_fall || tx_ninth) |=> irq_ff ##1 port_irq_flag_out)
    else $error("flag not raised on ninth fall");
  AST_UA_STRETCH: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (ua_ff && active) |=> !scl_oe_n_out)
    else $error("clock not held while update-address set");
  AST_UA_CLEAR: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (addr_wr_in && !set_ua) |=> !ua_ff ##1 !update_address_out)
    else $error("address write did not clear update-address");
  AST_BF_READ: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (buf_rd_in && !load_buf) |=> !bf_ff)
    else $error("buffer read did not clear full");
  AST_NACK_ENDS: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (tx_ninth && ack_seen_ff && active && !start_det && !stop_det) |=> state_ff == I2CS_ST_IDLE)
    else $error("not-acknowledge did not end transfer");
  AST_GC_NO_UA: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
    (decide && hit_gc && !hit_addr && ack_ok) |=> !after_ua_ff && phase_ff == I2CS_PH_DATA)
    else $error("general call raised update-address");

endmodule // i2cs_slave_port
`default_nettype wire

// *** dv/i2cs_master_model.sv ***
// Behavioural two-wire bus master that drives the slave port.
`timescale 1ns/10ps
`default_nettype none
module i2cs_master_model (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      scl_oe_n_out,
  output logic      sda_oe_n_out
);
  logic lnk_clk = 1'b0;
  always #15 lnk_clk = ~lnk_clk;
  initial begin
    scl_oe_n_out = 1'b1;
    sda_oe_n_out = 1'b1;
  end
  task tk(input int n);
    repeat (n) @(posedge lnk_clk);
  endtask
  // Releases the clock, then waits while a slave stretches it low.
  task rise();
    int i;
    scl_oe_n_out = 1'b1;
    for (i = 0; i < 4000 && scl_in !== 1'b1; i++) tk(1);
    tk(4);
  endtask
  task start();
    sda_oe_n_out = 1'b1;
    tk(2);
    rise();
    sda_oe_n_out = 1'b0;
    tk(4);
    scl_oe_n_out = 1'b0;
    tk(2);
  endtask
  task stop();
    sda_oe_n_out = 1'b0;
    tk(2);
    rise();
    sda_oe_n_out = 1'b1;
    tk(4);
  endtask
  task bit_io(input logic b, output logic r);
    sda_oe_n_out = b;
    tk(4);
    rise();
    r = sda_in;
    scl_oe_n_out = 1'b0;
    tk(2);
  endtask
  task wbyte(input logic [7:0] d, output logic nack);
    int i;
    for (i = 7; i >= 0; i--) bit_io(d[i], nack);
    bit_io(1'b1, nack);
  endtask
  task rbyte(input logic nack, output logic [7:0] d);
    int   i;
    logic x;
    for (i = 7; i >= 0; i--) begin
      bit_io(1'b1, x);
      d[i] = x;
    end
    bit_io(nack, x);
  endtask
endmodule  // i2cs_master_model
`default_nettype wire

// *** dv/tb_i2c_slave_port.sv ***
// Self-checking bench for the two-wire slave port.
`timescale 1ns/10ps
`default_nettype none
module tb_i2c_slave_port;
  import i2cs_pkg::*;
  localparam int PA = 0, PR = 1, PW = 2, PC = 3, PI = 4, PO = 5;
  logic       sys_clk = 1'b0;
  logic       rstn    = 1'b0;
  logic       en      = 1'b0;
  logic       gce     = 1'b0;
  logic [3:0] mode    = I2CS_MODE_MASTER;
  logic [5:0] pl      = 6'h00;
  logic [7:0] dat     = 8'h00;
  logic       d_scl, d_scl_oe_n, d_sda, d_sda_oe_n, m_scl_oe_n, m_sda_oe_n;
  logic       bf, ovf, ua, rw, crel, irq, scl_w, sda_w;
  logic [7:0] buffer, saddr;
  int         failures = 0;
  int         n_checks = 0;
  // Open-drain lines with pull-ups.
  assign scl_w = m_scl_oe_n & (d_scl_oe_n | d_scl);
  assign sda_w = m_sda_oe_n & (d_sda_oe_n | d_sda);
  always #4 sys_clk = ~sys_clk;
  i2cs_slave_port i2cs_slave_port_i (
    .sys_clk_in(sys_clk), .rstn_in(rstn), .scl_in(scl_w), .sda_in(sda_w),
    .scl_out(d_scl), .scl_oe_n_out(d_scl_oe_n), .sda_out(d_sda), .sda_oe_n_out(d_sda_oe_n),
    .port_enable_in(en), .mode_in(mode), .general_call_enable_in(gce),
    .addr_wr_in(pl[PA]), .addr_data_in(dat), .buf_rd_in(pl[PR]), .buf_wr_in(pl[PW]),
    .buf_data_in(dat), .clock_release_set_in(pl[PC]), .irq_clr_in(pl[PI]), .ovf_clr_in(pl[PO]),
    .rx_tx_buffer_out(buffer), .slave_address_out(saddr), .buffer_full_out(bf),
    .rx_overflow_out(ovf), .update_address_out(ua), .read_write_out(rw),
    .clock_release_out(crel), .port_irq_flag_out(irq));
  i2cs_master_model i2cs_master_model_i (
    .scl_in(scl_w), .sda_in(sda_w), .scl_oe_n_out(m_scl_oe_n), .sda_oe_n_out(m_sda_oe_n));
  task wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask
  task sw(input int k, input logic [7:0] d);
    @(negedge sys_clk);
    dat = d;
    pl[k] = 1'b1;
    @(negedge sys_clk);
    pl = 6'h00;
    wt(3);
  endtask
  task svc();
    sw(PR, 8'h00);
    sw(PI, 8'h00);
  endtask
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // Status order: full, overflow, update-address, read/write, flag.
  task st(input logic [4:0] e);
    chk("status", {3'h0, e}, {3'h0, bf, ovf, ua, rw, irq});
  endtask
  task bs();
    i2cs_master_model_i.start();
  endtask
  task bp();
    i2cs_master_model_i.stop();
  endtask
  task wr(input logic [7:0] d, input logic e);
    logic n;
    i2cs_master_model_i.wbyte(d, n);
    wt(8);
    chk("ack bit", {7'h00, e}, {7'h00, n});
  endtask
  task rd(input logic n, input logic [7:0] e);
    logic [7:0] g;
    i2cs_master_model_i.rbyte(n, g);
    wt(8);
    chk("read byte", e, g);
  endtask
  task tend(input string nm);
    $display("test %s done", nm);
  endtask
  task close_out();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    #500000;
    failures++;
    close_out();
  end
  initial begin
    wt(16);
    rstn = 1'b1;
    wt(2);
    st(5'h00);
    chk("release", 8'h01, {7'h00, crel});
    chk("line enables", 8'h03, {6'h00, d_scl_oe_n, d_sda_oe_n});
    // The address is loaded first so that only the enable or the mode can refuse the byte.
    sw(PA, 8'hA4);
    chk("address", 8'hA4, saddr);
    @(negedge sys_clk) en = 1'b1;
    bs();
    wr(8'hA4, 1'b1);
    bp();
    @(negedge sys_clk) mode = I2CS_MODE_SLAVE7;
    en = 1'b0;
    bs();
    wr(8'hA4, 1'b1);
    bp();
    st(5'h00);
    @(negedge sys_clk) en = 1'b1;
    tend("disabled and master mode");
    bs();
    wr(8'hA4, 1'b0);
    st(5'h11);
    chk("buffer", 8'hA4, buffer);
    svc();
    st(5'h00);
    wr(8'h5A, 1'b0);
    st(5'h11);
    chk("buffer", 8'h5A, buffer);
    sw(PI, 8'h00);
    wr(8'hC3, 1'b1);
    st(5'h19);
    chk("buffer", 8'h5A, buffer);
    svc();
    st(5'h08);
    wr(8'h3C, 1'b1);
    st(5'h19);
    chk("buffer", 8'h3C, buffer);
    sw(PO, 8'h00);
    svc();
    st(5'h00);
    bs();
    wr(8'hA6, 1'b1);
    st(5'h00);
    bp();
    tend("seven bit receive");
    bs();
    wr(8'hA5, 1'b0);
    st(5'h13);
    chk("clock hold", 8'h00, {7'h00, d_scl_oe_n});
    svc();
    sw(PW, 8'h96);
    sw(PC, 8'h00);
    rd(1'b0, 8'h96);
    st(5'h03);
    chk("hold after ack", 8'h00, {6'h00, crel, d_scl_oe_n});
    sw(PI, 8'h00);
    sw(PW, 8'hE1);
    sw(PC, 8'h00);
    rd(1'b1, 8'hE1);
    chk("flag", 8'h01, {7'h00, irq});
    bp();
    svc();
    tend("slave transmit");
    @(negedge sys_clk) gce = 1'b1;
    bs();
    wr(8'h00, 1'b0);
    st(5'h11);
    svc();
    wr(8'h5E, 1'b0);
    chk("buffer", 8'h5E, buffer);
    svc();
    @(negedge sys_clk) gce = 1'b0;
    bs();
    wr(8'h00, 1'b1);
    bp();
    tend("general call");
    @(negedge sys_clk) mode = I2CS_MODE_SLAVE10;
    sw(PA, 8'hF2);
    bs();
    wr(8'hF2, 1'b0);
    st(5'h15);
    chk("clock hold", 8'h00, {7'h00, d_scl_oe_n});
    sw(PA, 8'h35);
    svc();
    st(5'h00);
    chk("clock free", 8'h01, {7'h00, d_scl_oe_n});
    wr(8'h35, 1'b0);
    st(5'h15);
    sw(PA, 8'hF2);
    svc();
    wr(8'h77, 1'b0);
    chk("buffer", 8'h77, buffer);
    svc();
    bs();
    wr(8'hF3, 1'b0);
    st(5'h13);
    svc();
    sw(PW, 8'hAA);
    sw(PC, 8'h00);
    rd(1'b1, 8'hAA);
    bp();
    svc();
    @(negedge sys_clk) gce = 1'b1;
    bs();
    wr(8'h00, 1'b0);
    st(5'h11);
    svc();
    wr(8'h44, 1'b0);
    chk("buffer", 8'h44, buffer);
    svc();
    bp();
    tend("ten bit");
    bs();
    wr(8'hF2, 1'b0);
    @(negedge sys_clk) rstn = 1'b0;
    wt(3);
    st(5'h00);
    chk("line enables", 8'h03, {6'h00, d_scl_oe_n, d_sda_oe_n});
    chk("pin levels", 8'h00, {6'h00, d_scl, d_sda});
    rstn = 1'b1;
    wt(4);
    bp();
    tend("reset in transfer");
    close_out();
  end
endmodule  // tb_i2c_slave_port
`default_nettype wire
